// ==== rtl/ramp_log_pkg.sv ====
// constants, command codes and state type for the start-up ramp and status logger
package ramp_log_pkg;
    // =====================================================
    // command codes
    localparam logic [7:0] CMD_RAMP_HIST = 8'hDB;
    localparam logic [7:0] CMD_TEMP_SEL = 8'hDC;
    localparam logic [7:0] CMD_VIN_OFS = 8'hDD;
    localparam logic [7:0] CMD_VOUT_MON = 8'hDE;
    localparam logic [7:0] CMD_STAT_LOG = 8'hDF;
    // =====================================================
    // block lengths in bytes
    localparam logic [5:0] LEN_RAMP_HIST = 6'h20;
    localparam logic [5:0] LEN_TEMP_SEL = 6'h01;
    localparam logic [5:0] LEN_VIN_OFS = 6'h04;
    localparam logic [5:0] LEN_VOUT_MON = 6'h02;
    localparam logic [5:0] LEN_STAT_LOG = 6'h20;
    localparam logic [5:0] LEN_NONE = 6'h00;
    // =====================================================
    // layout
    localparam int RAMP_PAIRS = 15;
    localparam int STAT_WORDS = 16;
    localparam int RAMP_CNT_W = 16;
    localparam int RAMP_PAIR_BASE = 16;
    localparam int PAIR_W = 16;
    localparam int SAMPLE_W = 8;
    localparam int STAT_W = 16;
    localparam int TEMP_SEL_BIT = 0;
    localparam int TRIM_ON_LSB = 16;
    localparam logic [15:0] CNT_STEP = 16'h0001;
    localparam logic [3:0] STAT_LAST = 4'hF;
    localparam logic [3:0] RAMP_LAST = 4'hE;
    localparam logic [16:0] RAMP_GAPS = 17'h0000E;
    // =====================================================
    // timing
    localparam int CLK_HZ = 40_000_000;
    localparam int MS_PER_S = 1000;
    localparam int STAT_INTERVAL_S = 8;
    localparam int STAT_SPAN_S = 128;
    localparam int CYC_PER_MS = CLK_HZ / MS_PER_S;
    localparam int STAT_INTERVAL_CYC = STAT_INTERVAL_S * CLK_HZ;
    // =====================================================
    // logger states
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_RAMP = 4'b0010,
        ST_STAT = 4'b0100,
        ST_DONE = 4'b1000
    } log_state_t;
endpackage

// ==== rtl/tick_if.sv ====
// run and tick pair between the logger and its interval dividers
`timescale 1ns/1ps
interface tick_if;
    logic run;
    logic tick;
    modport gen (input run, output tick);
    modport user (output run, input tick);
endinterface

// ==== rtl/tick_divider.sv ====
// free divider giving a one-cycle enable every DIV cycles while run is high
`timescale 1ns/1ps
module tick_divider #(
    parameter int unsigned DIV = 40000
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // run and tick
    tick_if.gen t
);
    localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;
    localparam logic [CW-1:0] LAST = CW'(DIV - 1);
    logic [CW-1:0] cnt_r;
    logic [CW-1:0] cnt_nxt;

    // tick on the last count of each period
    assign t.tick = t.run && (cnt_r == LAST);

    // next count, held at zero while stopped
    always_comb begin
        if (!t.run || cnt_r == LAST) begin
            cnt_nxt = '0;
        end else begin
            cnt_nxt = cnt_r + CW'(1);
        end
    end

    // count register
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

    // after each tick the period must start again from zero
    tick_div_a: assert property (@(posedge clock) disable iff (rst)
        t.tick |=> cnt_r == '0)
        else $error("divider did not restart after its tick");
endmodule // tick_divider

// ==== rtl/ramp_status_logger.sv ====
// start-up ramp history, status log and trim readback command set
// Function
// - ramp history read returns one 32-byte block
// - capture fifteen input/output voltage sample pairs
// - sample spacing scales with configured ramp time
// - latch ramp counter just before ramp
// - latched counter is snapshot count plus one
// - only first ramp after power-up recorded
// - clear ramp log after successful ramp
// - counter low, then input/output byte pairs upward
// - bit 0 selects internal or external sensor
// - input offset upper half is turn-on trim
// - input offset lower half is turn-off trim
// - output trim read as signed 16-bit word
// - status logging starts right after successful ramp
// - status logging stops after 120 seconds
// - sixteen status words spaced eight seconds apart
// - status word n at bits 16n+15:16n
`timescale 1ns/1ps
module ramp_status_logger #(
    parameter int unsigned MS_DIV = ramp_log_pkg::CYC_PER_MS,
    parameter int unsigned STAT_DIV = ramp_log_pkg::STAT_INTERVAL_CYC
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // command port
    input wire logic cmd_valid,
    input wire logic cmd_write,
    input wire logic [7:0] cmd_code,
    input wire logic [7:0] wr_data,
    output logic rd_valid,
    output logic [255:0] rd_data,
    output logic [5:0] rd_len,
    output logic cmd_error,
    // ramp events and samples
    input wire logic ramp_begin,
    input wire logic ramp_ok,
    input wire logic ramp_fail,
    input wire logic [15:0] ramp_time_ms,
    input wire logic [7:0] vin_sample,
    input wire logic [7:0] vout_sample,
    input wire logic [15:0] snapshot_count,
    // status and trims
    input wire logic [15:0] status_word,
    input wire logic [15:0] vin_trim_on,
    input wire logic [15:0] vin_trim_off,
    input wire logic [15:0] vout_trim,
    // sensor select
    output logic temp_sel
);
    // =====================================================
    // state
    ramp_log_pkg::log_state_t state_r, state_nxt;
    logic ramp_seen_r, ramp_seen_nxt;
    logic [15:0] ramp_cnt_r, ramp_cnt_nxt;
    logic [3:0] ramp_idx_r, ramp_idx_nxt;
    logic [16:0] ramp_acc_r, ramp_acc_nxt;
    logic [3:0] stat_idx_r, stat_idx_nxt;
    logic [7:0] vin_r [ramp_log_pkg::RAMP_PAIRS];
    logic [7:0] vin_nxt [ramp_log_pkg::RAMP_PAIRS];
    logic [7:0] vout_r [ramp_log_pkg::RAMP_PAIRS];
    logic [7:0] vout_nxt [ramp_log_pkg::RAMP_PAIRS];
    logic [15:0] stat_r [ramp_log_pkg::STAT_WORDS];
    logic [15:0] stat_nxt [ramp_log_pkg::STAT_WORDS];
    logic [16:0] acc_sum;
    logic [16:0] ramp_len;
    tick_if ms_if ();
    tick_if st_if ();

    // =====================================================
    // interval dividers
    assign ms_if.run = (state_r == ramp_log_pkg::ST_RAMP);
    assign st_if.run = (state_r == ramp_log_pkg::ST_STAT);

    tick_divider #(.DIV(MS_DIV)) ms_div (
        .clock(clock),
        .rst(rst),
        .t(ms_if)
    );

    tick_divider #(.DIV(STAT_DIV)) stat_div (
        .clock(clock),
        .rst(rst),
        .t(st_if)
    );

    // ramp progress: each ms adds fourteen gaps' worth against the ramp length
    assign acc_sum = ramp_acc_r + ramp_log_pkg::RAMP_GAPS;
    assign ramp_len = {1'b0, ramp_time_ms};

    // =====================================================
    // logger next state
    always_comb begin
        state_nxt = state_r;
        ramp_seen_nxt = ramp_seen_r;
        ramp_cnt_nxt = ramp_cnt_r;
        ramp_idx_nxt = ramp_idx_r;
        ramp_acc_nxt = ramp_acc_r;
        stat_idx_nxt = stat_idx_r;
        vin_nxt = vin_r;
        vout_nxt = vout_r;
        stat_nxt = stat_r;
        case (state_r)
            ramp_log_pkg::ST_IDLE: begin
                if (ramp_begin && !ramp_seen_r) begin
                    ramp_seen_nxt = 1'b1;
                    ramp_cnt_nxt = snapshot_count + ramp_log_pkg::CNT_STEP;
                    vin_nxt[0] = vin_sample;
                    vout_nxt[0] = vout_sample;
                    ramp_idx_nxt = 4'h1;
                    ramp_acc_nxt = '0;
                    state_nxt = ramp_log_pkg::ST_RAMP;
                end
            end
            ramp_log_pkg::ST_RAMP: begin
                if (ramp_ok) begin
                    // clear the ramp record, open the status log
                    ramp_cnt_nxt = '0;
                    for (int i = 0; i < ramp_log_pkg::RAMP_PAIRS; i++) begin
                        vin_nxt[i] = '0;
                        vout_nxt[i] = '0;
                    end
                    stat_nxt[0] = status_word;
                    stat_idx_nxt = 4'h1;
                    state_nxt = ramp_log_pkg::ST_STAT;
                end else if (ramp_fail) begin
                    state_nxt = ramp_log_pkg::ST_DONE;
                end else if (ms_if.tick && ramp_idx_r <= ramp_log_pkg::RAMP_LAST) begin
                    if (acc_sum >= ramp_len) begin
                        vin_nxt[ramp_idx_r] = vin_sample;
                        vout_nxt[ramp_idx_r] = vout_sample;
                        ramp_idx_nxt = ramp_idx_r + 4'h1;
                        ramp_acc_nxt = acc_sum - ramp_len;
                    end else begin
                        ramp_acc_nxt = acc_sum;
                    end
                end
            end
            ramp_log_pkg::ST_STAT: begin
                if (st_if.tick) begin
                    stat_nxt[stat_idx_r] = status_word;
                    stat_idx_nxt = stat_idx_r + 4'h1;
                    if (stat_idx_r == ramp_log_pkg::STAT_LAST) begin
                        state_nxt = ramp_log_pkg::ST_DONE;
                    end
                end
            end
            ramp_log_pkg::ST_DONE: begin
                state_nxt = ramp_log_pkg::ST_DONE;
            end
            default: begin
                state_nxt = ramp_log_pkg::ST_IDLE;
            end
        endcase
    end

    // logger registers, all logs zero from power-up
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_r <= ramp_log_pkg::ST_IDLE;
            ramp_seen_r <= 1'b0;
            ramp_cnt_r <= '0;
            ramp_idx_r <= '0;
            ramp_acc_r <= '0;
            stat_idx_r <= '0;
            for (int i = 0; i < ramp_log_pkg::RAMP_PAIRS; i++) begin
                vin_r[i] <= '0;
                vout_r[i] <= '0;
            end
            for (int i = 0; i < ramp_log_pkg::STAT_WORDS; i++) begin
                stat_r[i] <= '0;
            end
        end else begin
            state_r <= state_nxt;
            ramp_seen_r <= ramp_seen_nxt;
            ramp_cnt_r <= ramp_cnt_nxt;
            ramp_idx_r <= ramp_idx_nxt;
            ramp_acc_r <= ramp_acc_nxt;
            stat_idx_r <= stat_idx_nxt;
            vin_r <= vin_nxt;
            vout_r <= vout_nxt;
            stat_r <= stat_nxt;
        end
    end

    // =====================================================
    // command decode and read answer
    logic temp_sel_r, temp_sel_nxt;
    logic rd_valid_r, rd_valid_nxt;
    logic [255:0] rd_data_r, rd_data_nxt;
    logic [5:0] rd_len_r, rd_len_nxt;
    logic cmd_error_r, cmd_error_nxt;
    logic [255:0] ramp_blk;
    logic [255:0] stat_blk;

    // block images of the two logs
    always_comb begin
        ramp_blk = '0;
        stat_blk = '0;
        ramp_blk[ramp_log_pkg::RAMP_CNT_W-1:0] = ramp_cnt_r;
        for (int i = 0; i < ramp_log_pkg::RAMP_PAIRS; i++) begin
            ramp_blk[ramp_log_pkg::RAMP_PAIR_BASE + i*ramp_log_pkg::PAIR_W
                     +: ramp_log_pkg::SAMPLE_W] = vin_r[i];
            ramp_blk[ramp_log_pkg::RAMP_PAIR_BASE + i*ramp_log_pkg::PAIR_W
                     + ramp_log_pkg::SAMPLE_W +: ramp_log_pkg::SAMPLE_W] = vout_r[i];
        end
        for (int i = 0; i < ramp_log_pkg::STAT_WORDS; i++) begin
            stat_blk[i*ramp_log_pkg::STAT_W +: ramp_log_pkg::STAT_W] = stat_r[i];
        end
    end

    // one read answer per known read command, the cycle after it is taken; writes give none
    always_comb begin
        temp_sel_nxt = temp_sel_r;
        rd_valid_nxt = 1'b0;
        rd_data_nxt = rd_data_r;
        rd_len_nxt = rd_len_r;
        cmd_error_nxt = 1'b0;
        if (cmd_valid && cmd_write) begin
            if (cmd_code == ramp_log_pkg::CMD_TEMP_SEL) begin
                temp_sel_nxt = wr_data[ramp_log_pkg::TEMP_SEL_BIT];
            end else begin
                cmd_error_nxt = 1'b1; // read-only or unknown
            end
        end else if (cmd_valid) begin
            rd_valid_nxt = 1'b1;
            rd_data_nxt = '0;
            if (cmd_code == ramp_log_pkg::CMD_RAMP_HIST) begin
                rd_data_nxt = ramp_blk;
                rd_len_nxt = ramp_log_pkg::LEN_RAMP_HIST;
            end else if (cmd_code == ramp_log_pkg::CMD_TEMP_SEL) begin
                rd_data_nxt[ramp_log_pkg::TEMP_SEL_BIT] = temp_sel_r;
                rd_len_nxt = ramp_log_pkg::LEN_TEMP_SEL;
            end else if (cmd_code == ramp_log_pkg::CMD_VIN_OFS) begin
                rd_data_nxt[ramp_log_pkg::TRIM_ON_LSB +: 16] = vin_trim_on;
                rd_data_nxt[15:0] = vin_trim_off;
                rd_len_nxt = ramp_log_pkg::LEN_VIN_OFS;
            end else if (cmd_code == ramp_log_pkg::CMD_VOUT_MON) begin
                rd_data_nxt[15:0] = vout_trim;
                rd_len_nxt = ramp_log_pkg::LEN_VOUT_MON;
            end else if (cmd_code == ramp_log_pkg::CMD_STAT_LOG) begin
                rd_data_nxt = stat_blk;
                rd_len_nxt = ramp_log_pkg::LEN_STAT_LOG;
            end else begin
                rd_valid_nxt = 1'b0;
                rd_len_nxt = ramp_log_pkg::LEN_NONE;
                cmd_error_nxt = 1'b1;
            end
        end
    end

    // command port registers
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            temp_sel_r <= 1'b0;
            rd_valid_r <= 1'b0;
            rd_data_r <= '0;
            rd_len_r <= '0;
            cmd_error_r <= 1'b0;
        end else begin
            temp_sel_r <= temp_sel_nxt;
            rd_valid_r <= rd_valid_nxt;
            rd_data_r <= rd_data_nxt;
            rd_len_r <= rd_len_nxt;
            cmd_error_r <= cmd_error_nxt;
        end
    end

    assign temp_sel = temp_sel_r;
    assign rd_valid = rd_valid_r;
    assign rd_data = rd_data_r;
    assign rd_len = rd_len_r;
    assign cmd_error = cmd_error_r;

    // =====================================================
    // checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    sequence ramp_start_s;
        state_r == ramp_log_pkg::ST_IDLE && !ramp_seen_r && ramp_begin;
    endsequence
    sequence ramp_done_s;
        state_r == ramp_log_pkg::ST_RAMP && ramp_ok;
    endsequence

    counter_latch_a: assert property (ramp_start_s |=>
        ramp_cnt_r == $past(snapshot_count) + ramp_log_pkg::CNT_STEP)
        else $error("ramp counter not snapshot plus one");
    later_ramp_a: assert property (ramp_seen_r && state_r == ramp_log_pkg::ST_DONE
        |=> state_r == ramp_log_pkg::ST_DONE && $stable(ramp_cnt_r))
        else $error("later ramp disturbed the log");
    ramp_clear_a: assert property (ramp_done_s |=> ramp_cnt_r == '0 && vin_r[0] == '0
        ##0 vout_r[ramp_log_pkg::RAMP_PAIRS-1] == '0)
        else $error("ramp log not cleared");
    stat_start_a: assert property (ramp_done_s |=> state_r == ramp_log_pkg::ST_STAT
        && stat_idx_r == 4'h1 && stat_r[0] == $past(status_word))
        else $error("status log did not start");
    stat_stop_a: assert property (state_r == ramp_log_pkg::ST_STAT && st_if.tick
        && stat_idx_r == ramp_log_pkg::STAT_LAST |=> state_r == ramp_log_pkg::ST_DONE)
        else $error("status log did not stop");
    ramp_count_a: assert property (ramp_idx_r == 4'hF |=> $stable(ramp_idx_r))
        else $error("too many ramp samples");
    ramp_read_a: assert property (cmd_valid && !cmd_write
        && cmd_code == ramp_log_pkg::CMD_RAMP_HIST |=> rd_valid && rd_len == 6'h20
        && rd_data[15:0] == $past(ramp_cnt_r))
        else $error("ramp block read wrong");
    sensor_write_a: assert property (cmd_valid && cmd_write
        && cmd_code == ramp_log_pkg::CMD_TEMP_SEL |=> temp_sel == $past(wr_data[0]))
        else $error("sensor select not written");
    vin_trim_a: assert property (cmd_valid && !cmd_write
        && cmd_code == ramp_log_pkg::CMD_VIN_OFS |=> rd_data[31:16] == $past(vin_trim_on)
        && rd_data[15:0] == $past(vin_trim_off) && rd_len == 6'h04)
        else $error("input offset read wrong");
    vout_trim_a: assert property (cmd_valid && !cmd_write
        && cmd_code == ramp_log_pkg::CMD_VOUT_MON |=> rd_data[15:0] == $past(vout_trim)
        && rd_data[255:16] == '0)
        else $error("output trim read wrong");
endmodule // ramp_status_logger

// ==== tb/pmbus_host.sv ====
// host model that issues one command at a time on the command port
`timescale 1ns/1ps
module pmbus_host (
    // clock
    input wire logic clock,
    // command request
    output logic cmd_valid,
    output logic cmd_write,
    output logic [7:0] cmd_code,
    output logic [7:0] wr_data,
    // answer
    input wire logic rd_valid,
    input wire logic [255:0] rd_data,
    input wire logic [5:0] rd_len,
    input wire logic cmd_error
);
    // =====================================================
    // idle request at time zero
    initial begin
        cmd_valid = 1'b0;
        cmd_write = 1'b0;
        cmd_code = 8'h00;
        wr_data = 8'h00;
    end
    // one request, answer taken in the cycle after the taking edge
    task automatic xfer(input logic w, input logic [7:0] code, input logic [7:0] d,
            output logic ok, output logic [255:0] data, output logic [5:0] len,
            output logic err);
        @(posedge clock);
        cmd_valid <= 1'b1;
        cmd_write <= w;
        cmd_code <= code;
        wr_data <= d;
        @(posedge clock);
        // released qualifiers stop showing the old request
        cmd_valid <= 1'b0;
        cmd_write <= ~w;
        cmd_code <= ~code;
        wr_data <= ~d;
        #1;
        ok = rd_valid;
        data = rd_data;
        len = rd_len;
        err = cmd_error;
    endtask
endmodule // pmbus_host

// ==== tb/test_startup_ramp_status_logger.sv ====
// self-checking bench for ramp history, status log and trim commands
`timescale 1ns/1ps
module test_startup_ramp_status_logger;
    // =====================================================
    // signals
    logic clock, rst, ramp_begin, ramp_ok, ramp_fail, cmd_valid, cmd_write;
    logic rd_valid, cmd_error, temp_sel, ok, err;
    logic [7:0] cmd_code, wr_data, vin_sample, vout_sample;
    logic [15:0] ramp_time_ms, snapshot_count, status_word, vin_trim_on, vin_trim_off;
    logic [15:0] vout_trim;
    logic [255:0] rd_data, dat;
    logic [5:0] rd_len, len;
    int n_fail = 0;
    int compares = 0;
    int cycles = 0;
    localparam logic [7:0] RO_CODES [4] = '{8'hDB, 8'hDD, 8'hDE, 8'hDF};
    // design and host model
    ramp_status_logger #(.MS_DIV(4), .STAT_DIV(20)) dut (.clock(clock), .rst(rst),
        .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_code(cmd_code),
        .wr_data(wr_data), .rd_valid(rd_valid), .rd_data(rd_data), .rd_len(rd_len),
        .cmd_error(cmd_error), .ramp_begin(ramp_begin), .ramp_ok(ramp_ok),
        .ramp_fail(ramp_fail), .ramp_time_ms(ramp_time_ms), .vin_sample(vin_sample),
        .vout_sample(vout_sample), .snapshot_count(snapshot_count),
        .status_word(status_word), .vin_trim_on(vin_trim_on),
        .vin_trim_off(vin_trim_off), .vout_trim(vout_trim), .temp_sel(temp_sel));
    pmbus_host host (.clock(clock), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
        .cmd_code(cmd_code), .wr_data(wr_data), .rd_valid(rd_valid), .rd_data(rd_data),
        .rd_len(rd_len), .cmd_error(cmd_error));
    // =====================================================
    // clock and hang guard
    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            n_fail++;
            results();
        end
    end
    // =====================================================
    // helpers
    task automatic cmd(input logic w, input logic [7:0] c, input logic [7:0] d);
        host.xfer(w, c, d, ok, dat, len, err);
    endtask
    task automatic chk(input string what, input logic [255:0] exp, input logic [255:0] got);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic do_reset();
        rst <= 1'b1;
        repeat (6) @(posedge clock);
        rst <= 1'b0;
    endtask
    task automatic results();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // counter low, then input/output byte pairs upward
    function automatic logic [255:0] ramp_exp(logic [15:0] c, logic [7:0] vi, logic [7:0] vo);
        logic [255:0] r;
        r = '0;
        r[15:0] = c;
        for (int n = 0; n < 15; n++) begin
            r[16 + 16 * n +: 16] = {vo, vi};
        end
        return r;
    endfunction
    // first n status words hold s, the rest stay zero
    function automatic logic [255:0] stat_exp(logic [15:0] s, int n);
        logic [255:0] r;
        r = '0;
        for (int k = 0; k < n; k++) begin
            r[16 * k +: 16] = s;
        end
        return r;
    endfunction
    // =====================================================
    // main sequence
    initial begin
        logic [15:0] snap, sw;
        logic [7:0] vi, vo;
        void'($urandom(32'h1835));
        {rst, ramp_begin, ramp_ok, ramp_fail} = 4'h8;
        {ramp_time_ms, snapshot_count, status_word} = '0;
        {vin_sample, vout_sample} = 16'h0000;
        {vin_trim_on, vin_trim_off, vout_trim} = '0;
        do_reset();
        // empty logs after power-up
        cmd(0, 8'hDB, 8'h00);
        chk("ramp len", 6'h20, len);
        chk("ramp empty", '0, dat);
        cmd(0, 8'hDF, 8'h00);
        chk("stat len", 6'h20, len);
        chk("stat empty", '0, dat);
        // trims, corner values first then random
        for (int i = 0; i < 4; i++) begin
            @(posedge clock);
            vin_trim_on <= (i == 0) ? 16'hFFFF : 16'($urandom);
            vin_trim_off <= (i == 0) ? 16'h0000 : 16'($urandom);
            vout_trim <= (i == 0) ? 16'h8000 : 16'($urandom);
            cmd(0, 8'hDD, 8'h00);
            chk("vin offsets", {vin_trim_on, vin_trim_off}, dat);
            chk("vin ofs len", 6'h04, len);
            cmd(0, 8'hDE, 8'h00);
            chk("vout trim", vout_trim, dat);
            chk("vout trim valid", 1'b1, ok);
        end
        // sensor source select, only bit 0 counts
        cmd(1, 8'hDC, 8'h01);
        chk("temp sel set", 1'b1, temp_sel);
        cmd(0, 8'hDC, 8'h00);
        chk("temp sel read", 8'h01, dat);
        cmd(1, 8'hDC, 8'hFE);
        chk("temp sel clear", 1'b0, temp_sel);
        // writes to read-only codes and an unknown read are refused
        foreach (RO_CODES[i]) begin
            cmd(1, RO_CODES[i], 8'hFF);
            chk("ro write err", 2'b10, {err, ok});
        end
        cmd(0, 8'hE0, 8'h00);
        chk("unknown read", 8'h80, {err, ok, len});
        // first ramp with the counter latched before it
        snap = 16'($urandom);
        vi = 8'($urandom);
        vo = 8'($urandom);
        @(posedge clock);
        snapshot_count <= snap;
        {vin_sample, vout_sample} <= {vi, vo};
        ramp_time_ms <= 16'h001C; // 28 ms ramp: one pair every 2 ms
        ramp_begin <= 1'b1;
        @(posedge clock);
        ramp_begin <= 1'b0;
        snapshot_count <= ~snap;
        cmd(0, 8'hDB, 8'h00);
        chk("ramp counter", 16'(snap + 16'h0001), dat[15:0]);
        chk("ramp pair 0", {vo, vi}, dat[31:16]);
        chk("ramp pair 14 pending", 16'h0000, dat[255:240]);
        // about 21 ms in: pairs up to 10 taken, 11 to 14 still pending
        repeat (80) @(posedge clock);
        cmd(0, 8'hDB, 8'h00);
        chk("ramp pair 10 taken", {vo, vi}, dat[191:176]);
        chk("ramp pairs 11-14 pending", '0, dat[255:192]);
        repeat (40) @(posedge clock);
        cmd(0, 8'hDB, 8'h00);
        chk("ramp block", ramp_exp(snap + 16'h0001, vi, vo), dat);
        // successful end, then a later ramp that must be ignored
        sw = 16'($urandom) | 16'h0001;
        @(posedge clock);
        status_word <= sw;
        ramp_ok <= 1'b1;
        @(posedge clock);
        ramp_ok <= 1'b0;
        ramp_begin <= 1'b1;
        @(posedge clock);
        ramp_begin <= 1'b0;
        cmd(0, 8'hDB, 8'h00);
        chk("ramp cleared", '0, dat);
        cmd(0, 8'hDF, 8'h00);
        chk("stat word 0", stat_exp(sw, 1), dat);
        repeat (22) @(posedge clock);
        cmd(0, 8'hDF, 8'h00);
        chk("stat spacing", stat_exp(sw, 2), dat);
        repeat (330) @(posedge clock);
        cmd(0, 8'hDF, 8'h00);
        chk("stat full", stat_exp(sw, 16), dat);
        @(posedge clock);
        status_word <= ~sw;
        repeat (60) @(posedge clock);
        cmd(0, 8'hDF, 8'h00);
        chk("stat stopped", stat_exp(sw, 16), dat);
        // failed ramp keeps its log and starts no status logging
        cmd(1, 8'hDC, 8'h01);
        do_reset();
        chk("sel after reset", 1'b0, temp_sel);
        @(posedge clock);
        snapshot_count <= snap;
        ramp_time_ms <= 16'h000E;
        ramp_begin <= 1'b1;
        @(posedge clock);
        ramp_begin <= 1'b0;
        repeat (80) @(posedge clock);
        ramp_fail <= 1'b1;
        @(posedge clock);
        ramp_fail <= 1'b0;
        {vin_sample, vout_sample} <= ~{vi, vo};
        ramp_begin <= 1'b1;
        @(posedge clock);
        ramp_begin <= 1'b0;
        repeat (80) @(posedge clock);
        cmd(0, 8'hDB, 8'h00);
        chk("ramp kept", ramp_exp(snap + 16'h0001, vi, vo), dat);
        cmd(0, 8'hDF, 8'h00);
        chk("no stat after fail", '0, dat);
        results();
    end
endmodule // test_startup_ramp_status_logger
